/* File: design/pts_period_tmr.sv */
// Purpose: Millisecond period timer that fires a one-cycle pulse
// Assumes: tick is a one-cycle pulse per millisecond on mclk
// Notes:   A period of zero stops the timer
`timescale 1ns/1ps
`default_nettype none
module pts_period_tmr (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic [15:0] period,
  // Event
  output logic fire
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_fire;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Next count and fire, restart from zero after each period
  always_comb begin
    next_cnt = cnt;
    next_fire = 1'b0;
    if (!enable || period == 16'h0000) begin
      next_cnt = 16'h0000;
    end else if (tick) begin
      if (cnt + 16'h0001 >= period) begin
        next_cnt = 16'h0000;
        next_fire = 1'b1;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 16'h0000;
      fire <= 1'b0;
    end else begin
      cnt <= next_cnt;
      fire <= next_fire;
    end
  end
endmodule
`default_nettype wire

/* File: design/pts_sched.sv */
// Purpose: Master-side scheduler for process-data, SYNC and heartbeat traffic
// Assumes: CAN controller logic on mclk gives one-cycle event pulses
// Notes:   Registers over APB, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
module pts_sched
  #(parameter int NCH = 4,
    parameter int MS_CYC = pts_pkg::MS_CYCLES)
  (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Process-data events from and to the CAN controller
  input wire logic [NCH-1:0] rx_data_chg,
  output logic [NCH-1:0] rx_send,
  input wire logic [NCH-1:0] tx_rcv,
  output logic [NCH-1:0] tx_valid,
  // Network management
  output logic sync_req,
  output logic hb_req,
  input wire logic [NCH-1:0] slave_alive,
  input wire logic slave_go_op,
  input wire logic sdo_ack,
  output logic sdo_req,
  output logic [4:0] sdo_index,
  output logic slave_op,
  // Applied link settings
  output logic [6:0] node_id,
  output logic [2:0] bit_rate,
  // Interrupt
  output logic irq
);
  import pts_pkg::*;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic run, restart;
  logic [15:0] sync_ms, hb_ms, guard_ms;
  logic [6:0] node_stage;
  logic [2:0] rate_stage;
  logic [31:0] rxtype;
  logic [EV_W-1:0] istat, imask;
  logic [4:0] sdo_cnt;
  logic [15:0] sync_act, hb_act, guard_act;
  logic [NCH-1:0] online;
  logic [EV_W-1:0] ev;
  logic wr_en, rd_hit;
  logic [31:0] rd_val;
  logic next_run, next_restart;
  logic [15:0] next_sync_ms, next_hb_ms, next_guard_ms;
  logic [6:0] next_node_stage;
  logic [2:0] next_rate_stage;
  logic [31:0] next_rxtype;
  logic [EV_W-1:0] next_istat, next_imask;
  logic [4:0] next_sdo_cnt;
  pts_sdo_t sdo_st;

  // Write lands at the edge where the master sees pready high
  assign wr_en = psel && penable && pready && pwrite;

  // Read decode, shared by data and error answers
  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a <= OFS_SDO) && (a[1:0] == 2'b00);
  endfunction

  always_comb begin
    rd_hit = map_hit(paddr);
    case (paddr)
      OFS_CTRL: rd_val = {30'h0, restart, run};
      OFS_SYNC: rd_val = {16'h0, sync_ms};
      OFS_HB: rd_val = {16'h0, hb_ms};
      OFS_NODE: rd_val = {21'h0, rate_stage, 1'b0, node_stage};
      OFS_ACTIVE: rd_val = {21'h0, bit_rate, 1'b0, node_id};
      OFS_RXTYPE: rd_val = rxtype;
      OFS_ISTAT: rd_val = {{(32-EV_W){1'b0}}, istat};
      OFS_IMASK: rd_val = {{(32-EV_W){1'b0}}, imask};
      OFS_ONLINE: rd_val = {{(32-NCH){1'b0}}, online};
      OFS_GUARD: rd_val = {16'h0, guard_ms};
      OFS_SDO: rd_val = {23'h0, sdo_st == PTS_SDO_DONE, 3'h0, sdo_cnt};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Register next values; hardware set wins over write-one-clear
  always_comb begin
    next_run = run;
    next_restart = 1'b0;
    next_sync_ms = sync_ms;
    next_hb_ms = hb_ms;
    next_guard_ms = guard_ms;
    next_node_stage = node_stage;
    next_rate_stage = rate_stage;
    next_rxtype = rxtype;
    next_imask = imask;
    next_sdo_cnt = sdo_cnt;
    next_istat = istat;
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          next_run = pwdata[CTRL_RUN];
          next_restart = pwdata[CTRL_RESTART];
        end
        OFS_SYNC: next_sync_ms = pwdata[15:0];
        OFS_HB: next_hb_ms = pwdata[15:0];
        OFS_NODE: begin
          next_node_stage = pwdata[6:0];
          next_rate_stage = pwdata[NODE_RATE_LSB +: 3];
        end
        OFS_RXTYPE: next_rxtype = pwdata;
        OFS_ISTAT: next_istat = istat & ~pwdata[EV_W-1:0];
        OFS_IMASK: next_imask = pwdata[EV_W-1:0];
        OFS_GUARD: next_guard_ms = pwdata[15:0];
        OFS_SDO: next_sdo_cnt = (pwdata[4:0] > SDO_MAX) ? SDO_MAX : pwdata[4:0];
        default: next_run = run;
      endcase
    end
    next_istat = next_istat | ev;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 1'b0;
      restart <= 1'b0;
      sync_ms <= SYNC_MS_RST;
      hb_ms <= HB_MS_RST;
      guard_ms <= GUARD_MS_RST;
      node_stage <= NODE_ID_RST;
      rate_stage <= RATE_1M;
      rxtype <= RXTYPE_RST;
      istat <= '0;
      imask <= '0;
      sdo_cnt <= 5'h00;
    end else begin
      run <= next_run;
      restart <= next_restart;
      sync_ms <= next_sync_ms;
      hb_ms <= next_hb_ms;
      guard_ms <= next_guard_ms;
      node_stage <= next_node_stage;
      rate_stage <= next_rate_stage;
      rxtype <= next_rxtype;
      istat <= next_istat;
      imask <= next_imask;
      sdo_cnt <= next_sdo_cnt;
    end
  end

  // APB answer: pready rises one cycle into the access phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_hit;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h00000000;
      irq <= |(next_istat & imask);
    end
  end

  // ----------------------------------------------------------------
  // Applied configuration
  // ----------------------------------------------------------------
  // Staged values move over only on a restart, whether or not run is set
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      node_id <= NODE_ID_RST;
      bit_rate <= RATE_1M;
      sync_act <= SYNC_MS_RST;
      hb_act <= HB_MS_RST;
      guard_act <= GUARD_MS_RST;
    end else if (restart) begin
      node_id <= node_stage;
      bit_rate <= rate_stage;
      sync_act <= sync_ms;
      hb_act <= hb_ms;
      guard_act <= guard_ms;
    end
  end

  // ----------------------------------------------------------------
  // Time base and periodic messages
  // ----------------------------------------------------------------
  logic [31:0] pre_cnt;
  logic ms_tick;
  logic sync_fire, hb_fire;

  // Millisecond enable; wide counter so the period can be shortened
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= 32'h00000000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (pre_cnt == 32'(MS_CYC - 1));
      pre_cnt <= (pre_cnt == 32'(MS_CYC - 1)) ? 32'h00000000 : pre_cnt + 32'h00000001;
    end
  end

  pts_period_tmr u_sync_tmr (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(ms_tick),
    .enable(run),
    .period(sync_act),
    .fire(sync_fire)
  );

  pts_period_tmr u_hb_tmr (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(ms_tick),
    .enable(run),
    .period(hb_act),
    .fire(hb_fire)
  );

  // Request pulses to the controller, one per period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_req <= 1'b0;
      hb_req <= 1'b0;
    end else begin
      sync_req <= sync_fire;
      hb_req <= hb_fire;
    end
  end

  // ----------------------------------------------------------------
  // Process-data channels
  // ----------------------------------------------------------------
  logic [NCH-1:0] chg_pend, send_now, tx_ev, off_ev;

  // Transmit objects arrive from slaves and are valid on receipt
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= '0;
      rx_send <= '0;
    end else begin
      tx_valid <= tx_rcv;
      rx_send <= send_now;
    end
  end
  assign tx_ev = tx_rcv;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [7:0] ttype;
    logic [7:0] cyc_cnt, next_cyc_cnt;
    logic next_chg;
    logic [15:0] ms_idle, next_ms_idle;
    logic alive_q, next_alive;
    assign ttype = rxtype[8*i +: 8];

    // Change flag and sync counter; a change in the send cycle is kept
    always_comb begin
      send_now[i] = 1'b0;
      next_chg = chg_pend[i];
      next_cyc_cnt = cyc_cnt;
      if (!run) begin
        next_chg = 1'b0;
        next_cyc_cnt = 8'h00;
      end else if (ttype == TT_ACYC || ttype == TT_EVT_A || ttype == TT_EVT_B) begin
        send_now[i] = chg_pend[i];
        next_chg = 1'b0;
      end else if (ttype <= TT_CYC_MAX && sync_fire) begin
        if (cyc_cnt + 8'h01 >= ttype) begin
          send_now[i] = 1'b1;
          next_cyc_cnt = 8'h00;
          next_chg = 1'b0;
        end else begin
          next_cyc_cnt = cyc_cnt + 8'h01;
        end
      end
      if (run && rx_data_chg[i]) begin
        next_chg = 1'b1;
      end
    end

    // Offline watch: idle time in ms against the guard limit
    always_comb begin
      next_ms_idle = ms_idle;
      next_alive = alive_q;
      off_ev[i] = 1'b0;
      if (!run || guard_act == 16'h0000 || slave_alive[i]) begin
        next_ms_idle = 16'h0000;
        next_alive = run && slave_alive[i] ? 1'b1 : alive_q;
      end else if (ms_tick) begin
        next_ms_idle = ms_idle + 16'h0001;
        if (next_ms_idle >= guard_act && alive_q) begin
          next_alive = 1'b0;
          off_ev[i] = 1'b1;
        end
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        chg_pend[i] <= 1'b0;
        cyc_cnt <= 8'h00;
        ms_idle <= 16'h0000;
        alive_q <= 1'b0;
      end else begin
        chg_pend[i] <= next_chg;
        cyc_cnt <= next_cyc_cnt;
        ms_idle <= next_ms_idle;
        alive_q <= next_alive;
      end
    end
    assign online[i] = alive_q;
  end

  // ----------------------------------------------------------------
  // Automatic SDO writes
  // ----------------------------------------------------------------
  pts_sdo_t next_sdo_st;
  logic [4:0] next_sdo_index;
  logic next_sdo_req, next_slave_op;

  // Writes go one at a time; operational after the last ack, or without any ack when the count is zero
  always_comb begin
    next_sdo_st = sdo_st;
    next_sdo_index = sdo_index;
    next_sdo_req = 1'b0;
    next_slave_op = slave_op;
    case (sdo_st)
      PTS_SDO_IDLE: begin
        if (slave_go_op) begin
          next_sdo_index = 5'h00;
          next_sdo_st = (sdo_cnt == 5'h00) ? PTS_SDO_DONE : PTS_SDO_ISSUE;
        end
      end
      PTS_SDO_ISSUE: begin
        next_sdo_req = 1'b1;
        next_sdo_st = PTS_SDO_WAIT;
      end
      PTS_SDO_WAIT: begin
        if (sdo_ack) begin
          next_sdo_index = sdo_index + 5'h01;
          next_sdo_st = (sdo_index + 5'h01 >= sdo_cnt) ? PTS_SDO_DONE : PTS_SDO_ISSUE;
        end
      end
      PTS_SDO_DONE: begin
        next_slave_op = 1'b1;
        if (restart) begin
          next_slave_op = 1'b0;
          next_sdo_st = PTS_SDO_IDLE;
        end
      end
      default: next_sdo_st = PTS_SDO_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_st <= PTS_SDO_IDLE;
      sdo_index <= 5'h00;
      sdo_req <= 1'b0;
      slave_op <= 1'b0;
    end else begin
      sdo_st <= next_sdo_st;
      sdo_index <= next_sdo_index;
      sdo_req <= next_sdo_req;
      slave_op <= next_slave_op;
    end
  end

  // Events into the sticky status
  always_comb begin
    ev = '0;
    ev[EV_SYNC] = sync_fire;
    ev[EV_OFFLINE] = |off_ev;
    ev[EV_SDO_DONE] = (sdo_st != PTS_SDO_DONE) && (next_sdo_st == PTS_SDO_DONE);
    ev[EV_TXPDO] = |tx_ev;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_SYNC_PULSE: assert property (sync_fire |=> sync_req && !$past(sync_req))
    else $error("sync request did not follow timer");
  AST_HB_PULSE: assert property (hb_fire |=> hb_req)
    else $error("heartbeat request missing");
  AST_TX_VALID: assert property (tx_rcv[0] |=> tx_valid[0])
    else $error("received transmit data not valid at once");
  AST_RX_CHG: assert property (
    run && rx_data_chg[1] && (rxtype[15:8] == TT_EVT_A || rxtype[15:8] == TT_EVT_B)
    ##1 run && (rxtype[15:8] == TT_EVT_A || rxtype[15:8] == TT_EVT_B) |=> rx_send[1])
    else $error("change did not send receive object");
  AST_RX_IDLE: assert property (
    run && rxtype[7:0] == TT_ACYC && !chg_pend[0] |=> !rx_send[0])
    else $error("unchanged data was sent");
  // Cyclic sends only ride on a SYNC
  AST_CYC_SEND: assert property (
    run && rxtype[23:16] != TT_ACYC && rxtype[23:16] <= TT_CYC_MAX && rx_send[2]
    |-> $past(sync_fire))
    else $error("cyclic object sent off the sync");
  AST_NODE_HOLD: assert property (!restart |=> $stable(node_id) && $stable(bit_rate))
    else $error("link settings changed without restart");
  AST_SDO_LIMIT: assert property (sdo_req |-> sdo_index < SDO_MAX)
    else $error("too many automatic writes");
  AST_OP_AFTER_SDO: assert property ($rose(slave_op) |-> $past(sdo_st) == PTS_SDO_DONE)
    else $error("operational before writes finished");
  AST_OFFLINE_EV: assert property (off_ev[0] |=> !online[0] && istat[EV_OFFLINE])
    else $error("offline not flagged");
  // A change in the clearing cycle may keep the flag
  AST_CHG_CLEAR: assert property (
    rx_send[1] && ($past(rxtype[15:8]) == TT_EVT_A || $past(rxtype[15:8]) == TT_EVT_B)
    |-> !chg_pend[1] || $past(rx_data_chg[1]))
    else $error("change flag not cleared after send");
endmodule
`default_nettype wire

/* File: include/pts_pkg.sv */
// Purpose: Shared constants for the process-data transmission scheduler
// Assumes: 200 MHz mclk, APB register access with 32-bit data
// Notes:   Timing figures are kept in their own unit, cycle counts are derived
package pts_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
  localparam logic [15:0] SYNC_MS_RST = 16'h0032;    // 50 ms cycle period
  localparam logic [15:0] HB_MS_RST = 16'h00C8;      // 200 ms heartbeat
  localparam logic [15:0] GUARD_MS_RST = 16'h0258;   // 600 ms offline limit
  // ----------------------------------------------------------------
  // Identity and link defaults
  // ----------------------------------------------------------------
  localparam logic [6:0] NODE_ID_RST = 7'h01;
  localparam logic [2:0] RATE_1M = 3'h0;             // Bit-rate code 0 = 1 Mbit/s
  localparam logic [4:0] SDO_MAX = 5'h14;            // At most 20 automatic writes
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SYNC = 8'h04;
  localparam logic [7:0] OFS_HB = 8'h08;
  localparam logic [7:0] OFS_NODE = 8'h0C;
  localparam logic [7:0] OFS_ACTIVE = 8'h10;
  localparam logic [7:0] OFS_RXTYPE = 8'h14;
  localparam logic [7:0] OFS_ISTAT = 8'h18;
  localparam logic [7:0] OFS_IMASK = 8'h1C;
  localparam logic [7:0] OFS_ONLINE = 8'h20;
  localparam logic [7:0] OFS_GUARD = 8'h24;
  localparam logic [7:0] OFS_SDO = 8'h28;
  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RESTART = 1;
  localparam int NODE_RATE_LSB = 8;
  localparam int EV_SYNC = 0;
  localparam int EV_OFFLINE = 1;
  localparam int EV_SDO_DONE = 2;
  localparam int EV_TXPDO = 3;
  localparam int EV_W = 4;
  // ----------------------------------------------------------------
  // Transmission types
  // ----------------------------------------------------------------
  localparam logic [7:0] TT_ACYC = 8'h00;
  localparam logic [7:0] TT_CYC_MAX = 8'hF0;
  localparam logic [7:0] TT_EVT_A = 8'hFE;
  localparam logic [7:0] TT_EVT_B = 8'hFF;
  localparam logic [31:0] RXTYPE_RST = 32'hFFFFFFFF;

  typedef enum logic [1:0] {PTS_SDO_IDLE, PTS_SDO_ISSUE, PTS_SDO_WAIT, PTS_SDO_DONE} pts_sdo_t;
endpackage

/* File: testbench/pts_slave_model.sv */
// Purpose: Behavioural slave node facing the scheduler
// Assumes: one-cycle event pulses on mclk
// Notes:   Ack delay comes from the bench, so answers are prompt or slow
`timescale 1ns/1ps
`default_nettype none
module pts_slave_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // From the master and the bench
  input wire logic sync_req,
  input wire logic sdo_req,
  input wire logic [3:0] tx_chg,
  input wire logic alive_en,
  input wire logic [2:0] ack_dly,
  // To the master
  output logic [3:0] tx_rcv,
  output logic [3:0] slave_alive,
  output logic sdo_ack
);
  logic [3:0] ack_cnt;
  logic [2:0] hb_cnt;
  logic [3:0] evt_cnt;
  // Slave traffic; ch0 has both timers zero, ch1 is cyclic type 1
  // Ch2 sends once per 16-cycle event period; inhibit is shorter, so never hit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_rcv <= 4'h0;
      slave_alive <= 4'h0;
      sdo_ack <= 1'b0;
      ack_cnt <= 4'h0;
      hb_cnt <= 3'h0;
      evt_cnt <= 4'h0;
    end else begin
      evt_cnt <= evt_cnt + 4'h1;
      tx_rcv <= {1'b0, tx_chg[2] && evt_cnt == 4'h0, sync_req & tx_chg[1], tx_chg[0]};
      hb_cnt <= hb_cnt + 3'h1;
      slave_alive <= {3'h0, alive_en && hb_cnt == 3'h0};
      // Ack counts down so a second request never overlaps the first
      if (sdo_req) begin
        ack_cnt <= {1'b0, ack_dly} + 4'h1;
      end else if (ack_cnt != 4'h0) begin
        ack_cnt <= ack_cnt - 4'h1;
      end
      sdo_ack <= (ack_cnt == 4'h1);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the process-data scheduler
// Assumes: MS_CYC shortened to 10 cycles per millisecond
// Notes:   Outputs are read right after the edge, before it lands
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pts_pkg::*;
  localparam int MSC = 10;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sync_req, hb_req, slave_go_op = 0, sdo_ack, sdo_req;
  logic [3:0] rx_data_chg = 4'h0, rx_send, tx_rcv, tx_valid, slave_alive;
  logic [3:0] tx_chg = 4'h2, prev_tx = 4'h0;
  logic [4:0] sdo_index;
  logic slave_op, irq, alive_en = 1, meas = 0;
  logic [6:0] node_id;
  logic [2:0] bit_rate, ack_dly = 3'h0;
  int mismatches = 0, num_checks = 0, cyc = 0, last_s, last_h, nsync, nsend2;
  int nsend01 = 0, nsend3 = 0, nchg = 0, exp_idx = 0;
  logic [7:0] ofs [7] = '{OFS_SYNC, OFS_HB, OFS_GUARD, OFS_NODE, OFS_RXTYPE, OFS_ISTAT, OFS_IMASK};
  logic [31:0] rv [7] = '{{16'h0, SYNC_MS_RST}, {16'h0, HB_MS_RST}, {16'h0, GUARD_MS_RST},
    {25'h0, NODE_ID_RST}, RXTYPE_RST, 32'h0, 32'h0};

  pts_sched #(.NCH(4), .MS_CYC(MSC)) dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_data_chg(rx_data_chg), .rx_send(rx_send),
    .tx_rcv(tx_rcv), .tx_valid(tx_valid), .sync_req(sync_req), .hb_req(hb_req),
    .slave_alive(slave_alive), .slave_go_op(slave_go_op), .sdo_ack(sdo_ack),
    .sdo_req(sdo_req), .sdo_index(sdo_index), .slave_op(slave_op), .node_id(node_id),
    .bit_rate(bit_rate), .irq(irq));
  pts_slave_model slave_u (.mclk(mclk), .rst_b(rst_b), .sync_req(sync_req),
    .sdo_req(sdo_req), .tx_chg(tx_chg), .alive_en(alive_en), .ack_dly(ack_dly),
    .tx_rcv(tx_rcv), .slave_alive(slave_alive), .sdo_ack(sdo_ack));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus and helpers
  // ----------------------------------------------------------------
  // Called just after a rising edge; ends one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Restart applies staged settings and reopens the measurement window
  task automatic restart();
    meas = 0;
    apb(1'b1, OFS_CTRL, 32'h3);
    last_s = 0;
    last_h = 0;
    nsync = 0;
    nsend2 = 0;
    meas = 1;
    repeat (2) @(posedge mclk);
  endtask
  // Random changes on event channels; ch3 has a type that never sends
  task automatic ev_test();
    int ch, n;
    for (int k = 0; k < 8; k++) begin
      ch = $urandom % 2;
      rx_data_chg <= {$urandom % 2 == 1, 1'b0, ch == 1, ch == 0};
      @(posedge mclk);
      rx_data_chg <= 4'h0;
      n = 0;
      while (rx_send[ch] !== 1'b1 && n < 6) begin
        @(posedge mclk);
        n++;
      end
      chk(n < 6, 1'b1);
      nchg++;
      repeat ($urandom % 4 + 3) @(posedge mclk);
    end
  endtask

  // Clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Watchdog against hangs
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end
  // Monitor of periodic and pulsed outputs
  always @(posedge mclk) begin
    cyc++;
    if (rst_b) begin
      chk(tx_valid, prev_tx);
      if (sync_req && meas) begin
        if (last_s != 0) chk(cyc - last_s, 2 * MSC);
        last_s = cyc;
        nsync++;
      end
      if (hb_req && meas) begin
        if (last_h != 0) chk(cyc - last_h, 3 * MSC);
        last_h = cyc;
      end
      if (rx_send[2] && meas) begin
        chk(sync_req, 1'b1);
        nsend2++;
      end
      if (sdo_req) begin
        chk(sdo_index, exp_idx[4:0]);
        exp_idx++;
      end
      nsend01 += rx_send[0] + rx_send[1];
      nsend3 += rx_send[3];
    end
    prev_tx = tx_rcv;
  end

  // Main sequence
  initial begin
    void'($urandom(9806));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chk(node_id, 7'h01);
    chk(bit_rate, RATE_1M);
    for (int i = 0; i < 7; i++) rdchk(ofs[i], rv[i]);
    rdchk(8'h2C, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 8'h05, 32'h0);
    chk(err, 1'b1);
    // Staged configuration; ch types 0, 254, 2, 245
    apb(1'b1, OFS_SYNC, 32'h2);
    apb(1'b1, OFS_HB, 32'h3);
    apb(1'b1, OFS_GUARD, 32'h3);
    apb(1'b1, OFS_NODE, 32'h205);
    apb(1'b1, OFS_RXTYPE, 32'hF502FE00);
    apb(1'b1, OFS_SDO, 32'h19);
    apb(1'b0, OFS_SDO, 32'h0);
    chk(rd[4:0], SDO_MAX);
    apb(1'b1, OFS_SDO, 32'h3);
    rdchk(OFS_ACTIVE, {25'h0, NODE_ID_RST});
    chk(node_id, 7'h01);
    restart();
    chk(node_id, 7'h05);
    chk(bit_rate, 3'h2);
    ev_test();
    repeat (130) @(posedge mclk);
    chk(nsend2 == nsync / 2 || nsend2 == (nsync + 1) / 2, 1'b1);
    // Interrupt: raise, mask, clear
    tx_chg <= 4'h0;
    repeat (3) @(posedge mclk);
    apb(1'b1, OFS_IMASK, 32'h0);
    tx_chg <= 4'h1;
    @(posedge mclk);
    tx_chg <= 4'h0;
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b1, OFS_IMASK, 32'h8);
    apb(1'b0, OFS_ISTAT, 32'h0);
    chk(rd[EV_TXPDO], 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, OFS_ISTAT, 32'h8);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    // Event-timed slave channel joins from here on
    tx_chg <= 4'h6;
    // Offline detection
    apb(1'b0, OFS_ONLINE, 32'h0);
    chk(rd[0], 1'b1);
    alive_en <= 1'b0;
    repeat (50) @(posedge mclk);
    apb(1'b0, OFS_ONLINE, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b0, OFS_ISTAT, 32'h0);
    chk(rd[EV_OFFLINE], 1'b1);
    // Automatic writes with random ack delays
    exp_idx = 0;
    slave_go_op <= 1'b1;
    @(posedge mclk);
    slave_go_op <= 1'b0;
    for (int n = 0; n < 200 && slave_op !== 1'b1; n++) begin
      ack_dly <= 3'($urandom % 8);
      @(posedge mclk);
    end
    chk(slave_op, 1'b1);
    chk(exp_idx, 3);
    apb(1'b0, OFS_ISTAT, 32'h0);
    chk(rd[EV_SDO_DONE], 1'b1);
    // Second round with type 255 on ch1
    apb(1'b1, OFS_RXTYPE, 32'hF502FF00);
    restart();
    ev_test();
    chk(nsend01, nchg);
    chk(nsend3, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
